// file: cpsc_ctrl.v
// Charge pilot state controller: pilot drive, state tracking, relays, ground fault.
// The fault detector pin is asynchronous and is
// synchronised here; the pilot sense code comes from a converter on this clock.
//
// How it works
// - Self-test first, then not-connected state.
// - Not connected: steady positive pilot, no pulses.
// - Connected level: start 1 kHz pulses, close relays.
// - Lower positive level means charging.
// - Idle level again: open relays, go idle.
// - Lowest level with negative half: ventilated charging.
// - Keep measuring pilot while pulses run.
// - Abnormal pilot condition cuts vehicle power.
// - Fault detector indication is a fault, except while the test winding runs and during its hold-off.
// - Ground fault opens relays at once.
// - Fault input synchronised, sampled each clock and acted on at level.
// - Drive self-test output into sensor winding.
// - Pilot is bipolar pulses at fixed 1 kHz.
`timescale 1ns/100ps
`include "cpsc_regs.vh"
`default_nettype none

module cpsc_ctrl
(
   input  wire       clk_i,            // 100 MHz system clock
   input  wire       arst_n_i,         // Power-on reset, active low
   input  wire [7:0] pilot_sense_i,    // Pilot sense code, this clock domain
   input  wire       sense_valid_i,    // Sense code valid pulse
   input  wire [7:0] duty_i,           // Pulse duty, percent, current advert
   input  wire       fault_det_i,      // Ground fault detector output, async
   input  wire       selftest_req_i,   // Request a fault path self-test
   input  wire       fault_clear_i,    // Leave error state after fault gone
   output reg        pilot_pos_o,      // High: pilot at positive rail, else negative
   output reg        relay_on_o,       // Power relays energised
   output reg        fault_test_o,     // Current into sensor test winding
   output reg        vent_req_o,       // Ventilation required
   output reg        ground_fault_o,   // Latched ground fault
   output reg        pilot_err_o,      // Pilot error state
   output reg  [2:0] state_o           // Controller state
);

   reg        rst_s1_r;
   reg        rst_n_r;
   reg        flt_s1_r;
   reg        flt_s2_r;
   reg        flt_s3_r;
   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [16:0] pwm_cnt_r;
   reg [16:0] test_cnt_r;
   reg        test_pass_r;
   reg        gf_r;
   reg [2:0]  lvl_hi_r;
   reg        neg_seen_r;
   reg        pos_seen_r;
   reg [2:0]  lvl_r;
   reg [7:0]  duty_r;
   reg [7:0]  blank_cnt_r;

   // Classify one sense sample into a pilot level
   function [2:0] cpsc_class;
      input [7:0] code;
      begin
         if (code >= `CPSC_TH_10V5)
            cpsc_class = `CPSC_LVL_12V;
         else if (code >= `CPSC_TH_7V5)
            cpsc_class = `CPSC_LVL_9V;
         else if (code >= `CPSC_TH_4V5)
            cpsc_class = `CPSC_LVL_6V;
         else if (code >= `CPSC_TH_1V5)
            cpsc_class = `CPSC_LVL_3V;
         else if (code >= `CPSC_TH_M1V5)
            cpsc_class = `CPSC_LVL_0V;
         else
            cpsc_class = `CPSC_LVL_NEG;
      end
   endfunction

   wire [2:0] samp_lvl = cpsc_class(pilot_sense_i);
   wire       pulsing  = (state_r == `CPSC_ST_CONNECTED) || (state_r == `CPSC_ST_CHARGING) ||
                         (state_r == `CPSC_ST_VENT);
   wire       pwm_wrap = (pwm_cnt_r == `CPSC_PWM_LAST);
   // Rising edge of the synchronised detector; gf_now is the sampled level, so a brief
   // pulse latches the fault only if a clock edge samples it, even if it ends before the next frame
   wire       flt_edge = flt_s2_r & ~flt_s3_r;
   wire       gf_now   = flt_edge | flt_s2_r;
   // Fault input is blind while the test winding runs and for a short
   // hold-off after it, so the test's own echo never latches a fault
   wire       test_mask = fault_test_o | (blank_cnt_r != `CPSC_BLANK_ZERO);
   // Duty threshold in cycles: duty percent times 1000 cycles; the
   // product stays below 2^17 because duty is clipped to 100 percent
   wire [16:0] duty_cyc = {9'h000, duty_r} * `CPSC_DUTY_STEP;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         flt_s1_r <= 1'b0;
         flt_s2_r <= 1'b0;
         flt_s3_r <= 1'b0;
      end
      else
      begin
         flt_s1_r <= fault_det_i;
         flt_s2_r <= flt_s1_r;
         flt_s3_r <= flt_s2_r;
      end
   end

   // Duty is only reloaded at period wrap so a pulse is never cut short
   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         pwm_cnt_r <= `CPSC_CNT_ZERO;
         duty_r    <= `CPSC_DUTY_RESET;
      end
      else
      begin
         pwm_cnt_r <= pwm_wrap ? `CPSC_CNT_ZERO : pwm_cnt_r + 17'h00001;
         if (pwm_wrap)
            duty_r <= (duty_i > `CPSC_DUTY_FULL) ? `CPSC_DUTY_FULL : duty_i;
      end
   end

   // Pilot measurement: highest positive level and whether a negative half
   // showed up, gathered over one pulse period, then committed
   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         lvl_hi_r   <= `CPSC_LVL_NEG;
         neg_seen_r <= 1'b0;
         pos_seen_r <= 1'b0;
         lvl_r      <= `CPSC_LVL_12V;
      end
      else
      begin
         if (pwm_wrap)
         begin
            if (!pulsing)
               lvl_r <= lvl_hi_r;
            else if (!pos_seen_r)
               lvl_r <= neg_seen_r ? `CPSC_LVL_NEG : `CPSC_LVL_0V;
            else if (!neg_seen_r && lvl_hi_r != `CPSC_LVL_12V)
               lvl_r <= `CPSC_LVL_0V;
            else
               lvl_r <= lvl_hi_r;
            lvl_hi_r   <= `CPSC_LVL_NEG;
            neg_seen_r <= 1'b0;
            pos_seen_r <= 1'b0;
         end
         else if (sense_valid_i)
         begin
            if (pilot_pos_o)
            begin
               if (samp_lvl < lvl_hi_r)
                  lvl_hi_r <= samp_lvl;
               if (samp_lvl <= `CPSC_LVL_3V)
                  pos_seen_r <= 1'b1;
            end
            else if (pilot_sense_i <= `CPSC_TH_M10V)
               neg_seen_r <= 1'b1;
         end
      end
   end

   // Self-test: drive test winding for a fixed time, expect detector to fire
   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         test_cnt_r  <= `CPSC_CNT_ZERO;
         test_pass_r <= 1'b0;
         fault_test_o <= 1'b0;
      end
      else
      begin
         // Every entry into self-test starts a fresh run, also after an error
         if ((state_r == `CPSC_ST_SELFTEST && !fault_test_o) ||
             (state_r == `CPSC_ST_IDLE && selftest_req_i && !fault_test_o))
         begin
            fault_test_o <= 1'b1;
            test_cnt_r   <= `CPSC_CNT_ZERO;
            test_pass_r  <= 1'b0;
         end
         else if (fault_test_o)
         begin
            if (flt_s2_r)
               test_pass_r <= 1'b1;
            if (test_cnt_r == `CPSC_TEST_LAST)
               fault_test_o <= 1'b0;
            else
               test_cnt_r <= test_cnt_r + 17'h00001;
         end
      end
   end

   // Hold-off after the test winding goes quiet: the echo still runs
   // through the synchroniser and the detector needs time to discharge.
   // A real fault in this short window is caught once the window closes,
   // as long as the detector still signals it.
   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
         blank_cnt_r <= `CPSC_BLANK_ZERO;
      else if (fault_test_o)
         blank_cnt_r <= `CPSC_BLANK_LAST;
      else if (blank_cnt_r != `CPSC_BLANK_ZERO)
         blank_cnt_r <= blank_cnt_r - 8'h01;
   end

   // Latched ground fault; set outside self-test, set wins over clear
   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
         gf_r <= 1'b0;
      else if (gf_now && !test_mask)
         gf_r <= 1'b1;
      else if (fault_clear_i && state_r == `CPSC_ST_ERROR)
         gf_r <= 1'b0;
   end

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         `CPSC_ST_SELFTEST:
            if (fault_test_o && test_cnt_r == `CPSC_TEST_LAST)
               state_nxt = (test_pass_r || flt_s2_r) ? `CPSC_ST_IDLE : `CPSC_ST_ERROR;
         `CPSC_ST_IDLE:
            if (lvl_r == `CPSC_LVL_9V)
               state_nxt = `CPSC_ST_CONNECTED;
         `CPSC_ST_CONNECTED, `CPSC_ST_CHARGING, `CPSC_ST_VENT:
            case (lvl_r)
               `CPSC_LVL_12V: state_nxt = `CPSC_ST_IDLE;
               `CPSC_LVL_9V:  state_nxt = `CPSC_ST_CONNECTED;
               `CPSC_LVL_6V:  state_nxt = `CPSC_ST_CHARGING;
               `CPSC_LVL_3V:  state_nxt = `CPSC_ST_VENT;
               default:       state_nxt = `CPSC_ST_ERROR;
            endcase
         `CPSC_ST_ERROR:
            if (fault_clear_i && !gf_r && !flt_s2_r)
               state_nxt = `CPSC_ST_SELFTEST;
         default:
            state_nxt = `CPSC_ST_ERROR;
      endcase
      if (gf_now && !test_mask && state_r != `CPSC_ST_SELFTEST)
         state_nxt = `CPSC_ST_ERROR;
   end

   always @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r        <= `CPSC_ST_SELFTEST;
         state_o        <= `CPSC_ST_SELFTEST;
         pilot_pos_o    <= 1'b1;
         relay_on_o     <= 1'b0;
         vent_req_o     <= 1'b0;
         ground_fault_o <= 1'b0;
         pilot_err_o    <= 1'b0;
      end
      else
      begin
         state_r        <= state_nxt;
         state_o        <= state_nxt;
         // Relays follow the next state, so a fault opens them in one cycle
         relay_on_o     <= (state_nxt == `CPSC_ST_CONNECTED) ||
                           (state_nxt == `CPSC_ST_CHARGING) ||
                           (state_nxt == `CPSC_ST_VENT);
         vent_req_o     <= (state_nxt == `CPSC_ST_VENT);
         ground_fault_o <= gf_r | (gf_now & ~test_mask);
         pilot_err_o    <= (state_nxt == `CPSC_ST_ERROR);
         if (pulsing)
            pilot_pos_o <= (pwm_cnt_r < duty_cyc);
         else if (state_r == `CPSC_ST_ERROR)
            pilot_pos_o <= 1'b0;
         else
            pilot_pos_o <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: cpsc_regs.vh
// Constants for the charge pilot state controller: states, timing, pilot levels.
// Assumes a 100 MHz system clock and a pilot sense converter code of 8 bits.
`ifndef CPSC_REGS_VH
`define CPSC_REGS_VH

// Controller states
`define CPSC_ST_SELFTEST   3'h0
`define CPSC_ST_IDLE       3'h1
`define CPSC_ST_CONNECTED  3'h2
`define CPSC_ST_CHARGING   3'h3
`define CPSC_ST_VENT       3'h4
`define CPSC_ST_ERROR      3'h5

// Pilot level classes from the sense path
`define CPSC_LVL_12V       3'h0
`define CPSC_LVL_9V        3'h1
`define CPSC_LVL_6V        3'h2
`define CPSC_LVL_3V        3'h3
`define CPSC_LVL_0V        3'h4
`define CPSC_LVL_NEG       3'h5

// Sense code thresholds (sense code = volts scaled into 0..255 over -12..+12 V)
`define CPSC_TH_10V5       8'hEF
`define CPSC_TH_7V5        8'hDF
`define CPSC_TH_4V5        8'hCF
`define CPSC_TH_1V5        8'hBF
`define CPSC_TH_M1V5       8'h6F
`define CPSC_TH_M10V       8'h15

// Timing
`define CPSC_CLK_HZ        100000000
`define CPSC_PWM_HZ        1000
`define CPSC_PWM_PERIOD    (`CPSC_CLK_HZ / `CPSC_PWM_HZ)
`define CPSC_PWM_LAST      17'h1869F
`define CPSC_PWM_PER_W     17'h186A0
`define CPSC_TEST_US       1000
`define CPSC_TEST_CYC      (`CPSC_TEST_US * 100)
`define CPSC_TEST_LAST     17'h1869F
`define CPSC_CNT_ZERO      17'h00000
`define CPSC_DUTY_RESET    8'h32
`define CPSC_DUTY_FULL     8'h64
`define CPSC_DUTY_STEP     17'h003E8
`define CPSC_BLANK_LAST    8'hFF
`define CPSC_BLANK_ZERO    8'h00

`endif

// file: cpsc_ctrl_monitor.sv
// Assertion checker for cpsc_ctrl, attached by bind.
// Assumes one 100 MHz domain and the controller's state encoding.
`timescale 1ns/100ps
`include "cpsc_regs.vh"
`default_nettype none
module cpsc_ctrl_monitor
(
   input wire logic       clk_i,          // clock
   input wire logic       arst_n_i,       // reset
   input wire logic       fault_det_i,    // detector
   input wire logic       pilot_pos_o,    // pilot rail
   input wire logic       relay_on_o,     // relays
   input wire logic       fault_test_o,   // test winding
   input wire logic       vent_req_o,     // ventilation
   input wire logic       ground_fault_o, // fault latch
   input wire logic       pilot_err_o,    // error flag
   input wire logic [2:0] state_o         // state
);
   reg         pp_r;
   reg         arm_r;
   reg  [16:0] per_r;
   reg  [3:0]  st_r;
   wire        puls_w;
   assign puls_w = state_o >= `CPSC_ST_CONNECTED && state_o <= `CPSC_ST_VENT;
   // First rise after entering a pulsing state is partial, so it only arms
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pp_r  <= 1'b1;
         arm_r <= 1'b0;
         per_r <= `CPSC_CNT_ZERO;
         st_r  <= 4'h0;
      end
      else
      begin
         pp_r  <= pilot_pos_o;
         per_r <= (pilot_pos_o && !pp_r) ? 17'h00001 : per_r + 17'h00001;
         arm_r <= puls_w && ((pilot_pos_o && !pp_r) || arm_r);
         st_r  <= (state_o != `CPSC_ST_SELFTEST) ? 4'h0 : (st_r == 4'hF) ? st_r : st_r + 4'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   steady_idle_a: assert property ((state_o == `CPSC_ST_IDLE)[*3] |-> pilot_pos_o)
      else $error("pilot not steady in idle");
   idle_relay_a: assert property ((state_o == `CPSC_ST_IDLE)[*2] |-> !relay_on_o)
      else $error("relays on in idle");
   conn_relay_a: assert property ($rose(state_o == `CPSC_ST_CONNECTED) |-> ##[1:2] relay_on_o)
      else $error("relays not closed on connect");
   err_out_a: assert property ((state_o == `CPSC_ST_ERROR)[*2] |-> pilot_err_o && !relay_on_o)
      else $error("error state outputs wrong");
   gf_cut_a: assert property ($rose(fault_det_i) && puls_w |-> ##[1:6] (ground_fault_o && !relay_on_o))
      else $error("ground fault not acted on");
   vent_flag_a: assert property ((state_o == `CPSC_ST_VENT)[*2] |-> vent_req_o)
      else $error("ventilation flag missing");
   test_drive_a: assert property (st_r == 4'hA |-> fault_test_o)
      else $error("self-test current missing");
   pwm_period_a: assert property (pilot_pos_o && !pp_r && puls_w && arm_r |-> per_r == `CPSC_PWM_PER_W)
      else $error("pilot period wrong");
   cover property ($rose(state_o == `CPSC_ST_CHARGING));
   cover property ($rose(vent_req_o));
   cover property ($rose(ground_fault_o));
endmodule
`default_nettype wire

// file: cpsc_vehicle.sv
// Vehicle model: load on the pilot seen through the sense converter.
// Assumes the controller's sense code scale; a sparse mode thins samples.
`timescale 1ns/100ps
`include "cpsc_regs.vh"
`default_nettype none
module cpsc_vehicle
(
   input  wire logic       clk_i,       // clock
   input  wire logic       pilot_pos_i, // pilot rail
   input  wire logic [2:0] level_i,     // load class
   input  wire logic       diode_i,     // diode fitted
   input  wire logic       slow_i,      // sparse samples
   output var  logic [7:0] sense_o,     // sense code
   output var  logic       valid_o      // sample valid
);
   localparam logic [7:0] POS_C [0:4] = '{8'hF8, 8'hE6, 8'hD6, 8'hC6, 8'h80};
   initial valid_o = 1'b1;
   // Without the diode the negative half is loaded well above the rail
   always @(posedge clk_i)
   begin
      sense_o <= #1 pilot_pos_i ? POS_C[level_i] : (diode_i ? 8'h05 : 8'h30);
      valid_o <= #1 slow_i ? ~valid_o : 1'b1;
   end
endmodule
`default_nettype wire

// file: test_charge_pilot_state_controller.sv
// Self-checking bench for cpsc_ctrl with a vehicle model and fault detector.
// Assumes 100 MHz clock; detector echoes the test winding current.
`timescale 1ns/100ps
`include "cpsc_regs.vh"
`default_nettype none
module test_charge_pilot_state_controller;
   logic       clk_i = 1'b0;
   logic       arst_n_i = 1'b0;
   logic [7:0] duty = 8'h32;
   logic       fdet = 1'b0;
   logic       clr = 1'b0;
   logic       gf = 1'b0;
   logic       diode = 1'b1;
   logic       slow = 1'b0;
   logic       streq = 1'b0;
   logic [2:0] level = `CPSC_LVL_12V;
   logic [3:0] exp_q[$];
   logic [2:0] last_st = `CPSC_ST_SELFTEST;
   wire  [7:0] sense;
   wire        valid;
   wire        pilot_pos;
   wire        relay_on;
   wire        fault_test;
   wire        gfault;
   wire        vent;
   wire        perr;
   wire  [2:0] state;
   int         n_mismatch = 0;
   int         comparisons = 0;
   int         hi;
   int         seed;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) fdet <= #1 fault_test | gf;
   cpsc_ctrl cpsc_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .pilot_sense_i(sense),
      .sense_valid_i(valid), .duty_i(duty), .fault_det_i(fdet), .selftest_req_i(streq),
      .fault_clear_i(clr), .pilot_pos_o(pilot_pos), .relay_on_o(relay_on),
      .fault_test_o(fault_test), .vent_req_o(vent), .ground_fault_o(gfault),
      .pilot_err_o(perr), .state_o(state));
   cpsc_vehicle cpsc_vehicle_inst (.clk_i(clk_i), .pilot_pos_i(pilot_pos), .level_i(level),
      .diode_i(diode), .slow_i(slow), .sense_o(sense), .valid_o(valid));
   task chk_note(input logic [3:0] exp, input logic [3:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: relay/state %h, expected %h", $time, got, exp);
      end
   endtask
   task chk_count(input int exp, input int got);
      comparisons++;
      if (got < exp - 1 || got > exp + 1)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask
   task note(input logic [2:0] st, input logic r);
      exp_q.push_back({r, st});
   endtask
   task go(input logic [2:0] st, input int lim);
      int i;
      i = 0;
      while (state !== st && i < lim)
      begin
         @(negedge clk_i);
         i++;
      end
      if (i >= lim)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: state %0d not reached", $time, st);
      end
      $display("Step done at %0t, state %0d", $time, st);
   endtask
   task step(input logic [2:0] lvl, input logic dio, input logic [2:0] st, input logic r);
      @(posedge clk_i);
      #1;
      level = lvl;
      diode = dio;
      slow = 1'($urandom % 2);
      note(st, r);
      go(st, 250000);
   endtask
   task meas(input int n);
      hi = 0;
      repeat (n) @(negedge clk_i) hi += (pilot_pos === 1'b1);
   endtask
   task conclude;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // State changes are noted by the driver; relays change on the same clock edge as state
   always @(negedge clk_i)
      if (state !== last_st)
      begin
         last_st = state;
         repeat (2) @(negedge clk_i);
         chk_note(exp_q.size() ? exp_q.pop_front() : 4'hF, {relay_on, last_st});
      end
   initial
   begin
      #40000000;
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude;
   end
   initial
   begin
      seed = $urandom(64455);
      duty = 8'(10 + $urandom % 81);
      repeat (6) @(posedge clk_i);
      #1 arst_n_i = 1'b1;
      note(`CPSC_ST_IDLE, 1'b0);
      go(`CPSC_ST_IDLE, 120000);
      @(posedge clk_i) #1 streq = 1'b1;
      @(posedge clk_i) #1 streq = 1'b0;
      meas(2000);
      chk_note({1'b1, `CPSC_ST_IDLE}, {fault_test, state});
      chk_count(2000, hi);
      step(`CPSC_LVL_9V, 1'b1, `CPSC_ST_CONNECTED, 1'b1);
      meas(100000);
      chk_count(int'(duty) * 1000, hi);
      step(`CPSC_LVL_6V, 1'b1, `CPSC_ST_CHARGING, 1'b1);
      step(`CPSC_LVL_3V, 1'b1, `CPSC_ST_VENT, 1'b1);
      chk_note({1'b1, `CPSC_ST_VENT}, {vent, state});
      step(`CPSC_LVL_12V, 1'b1, `CPSC_ST_IDLE, 1'b0);
      step(`CPSC_LVL_9V, 1'b1, `CPSC_ST_CONNECTED, 1'b1);
      step(`CPSC_LVL_9V, 1'b0, `CPSC_ST_ERROR, 1'b0);
      chk_note({1'b1, `CPSC_ST_ERROR}, {perr, state});
      @(posedge clk_i) #1 clr = 1'b1;
      step(`CPSC_LVL_12V, 1'b1, `CPSC_ST_SELFTEST, 1'b0);
      @(posedge clk_i) #1 clr = 1'b0;
      note(`CPSC_ST_IDLE, 1'b0);
      go(`CPSC_ST_IDLE, 120000);
      step(`CPSC_LVL_9V, 1'b1, `CPSC_ST_CONNECTED, 1'b1);
      @(posedge clk_i) #1 gf = 1'b1;
      note(`CPSC_ST_ERROR, 1'b0);
      go(`CPSC_ST_ERROR, 8);
      repeat (3) @(negedge clk_i);
      chk_note({1'b1, `CPSC_ST_ERROR}, {gfault, state});
      conclude;
   end
endmodule
bind cpsc_ctrl cpsc_ctrl_monitor cpsc_ctrl_monitor_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .fault_det_i(fault_det_i), .pilot_pos_o(pilot_pos_o), .relay_on_o(relay_on_o),
   .fault_test_o(fault_test_o), .vent_req_o(vent_req_o), .ground_fault_o(ground_fault_o),
   .pilot_err_o(pilot_err_o), .state_o(state_o));
`default_nettype wire
